// ==== pkg/cbt_pkg.sv ====
// constants and types for the can bit timing / tx status / rx fifo 1 config block
// assumes a classic wishbone master with 32-bit data, one clock domain
// Notes on behaviour
// - timing writable only when change-enable and init set
// - bit time spans 3 to 385 quanta
// - quantum is prescaler plus one clocks
// - jump width seven bits at top
// - partial store: no put advance, no new-data
// - ram fetch late: set failure flag, abort
// - access failure enters restricted mode until cleared
// - timestamp rollover sets bit 16 flag
// - event lost, or write to zero-size fifo, bit 15
// - event fifo full flag at bit 14
// - event fifo watermark reached flag at bit 13
// - event fifo new entry flag at bit 12
// - tx fifo empty flag at bit 11
// - cancellation finished flag at bit 10
// - fifo 1 bit 31 selects overwrite mode
// - watermark 1..64 active, else disabled
// - size zero none, above 64 means 64
// - start address word aligned, low bits zero
// - change-enable writable only while init set
// - software reads init back before changing it
package cbt_pkg;
	// ****************************************************
	// register map (byte addresses)
	// ****************************************************
	localparam logic [7:0] CBT_CORE_CTRL_OFF = 8'h18;
	localparam logic [7:0] CBT_NBT_OFF = 8'h1C;
	localparam logic [7:0] CBT_IRQ_FLAGS_OFF = 8'h50;
	localparam logic [7:0] CBT_RXF1_CFG_OFF = 8'hB8;
	localparam logic [7:0] CBT_TQ_STATUS_OFF = 8'hC0;
	// ****************************************************
	// reset values
	// ****************************************************
	localparam logic [31:0] CBT_NBT_RST = 32'h00000A33;
	localparam logic [31:0] CBT_CORE_CTRL_RST = 32'h00000001;
	// ****************************************************
	// field positions
	// ****************************************************
	localparam int CBT_INIT_BIT = 0;
	localparam int CBT_CFG_CHANGE_BIT = 1;
	localparam int CBT_ROM_BIT = 2;
	localparam int CBT_MRAF_BIT = 17;
	localparam int CBT_TS_WRAP_BIT = 16;
	localparam int CBT_EVT_LOST_BIT = 15;
	localparam int CBT_EVT_FULL_BIT = 14;
	localparam int CBT_EVT_WM_BIT = 13;
	localparam int CBT_EVT_NEW_BIT = 12;
	localparam int CBT_TXQ_EMPTY_BIT = 11;
	localparam int CBT_CANCEL_BIT = 10;
	localparam int CBT_RXF1_WM_BIT = 9;
	localparam int CBT_RXF1_OM_BIT = 31;
	localparam logic [31:0] CBT_FLAG_MASK = 32'h0003FE00;
	localparam logic [6:0] CBT_F1_MAX = 7'h40;
	localparam logic [15:0] CBT_RXF1_SA_MASK = 16'hFFFC;
	localparam int CBT_MIN_TQ = 4;
	localparam int CBT_MAX_TQ = 385;

	typedef struct packed {
		logic [6:0] jump_width;
		logic [8:0] prescaler;
		logic [7:0] seg_before;
		logic [7:0] seg_after;
	} cbt_nbt_s;

	typedef struct packed {
		logic overwrite_mode;
		logic [6:0] watermark;
		logic reserved;
		logic [6:0] size;
		logic [15:0] start_address;
	} cbt_rxf1_s;

	// tx-side events, one-cycle pulses or levels from the tx handler
	typedef struct packed {
		logic ts_wrap;
		logic evt_write;
		logic evt_lost;
		logic ram_late;
		logic cancel_done;
	} cbt_tx_evt_s;

	typedef enum logic [1:0] {CBT_IDLE, CBT_ACK} cbt_bus_e;
endpackage

// ==== rtl/cbt_core.sv ====
// bit timing, tx handler flags and rx fifo 1 configuration
// assumes events and rx store strobes come from logic on clk_i
`timescale 1ns/1ps
module cbt_core
	import cbt_pkg::*;
#(
	parameter int EVT_DEPTH_W = 6
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	// tx handler events
	input wire cbt_tx_evt_s tx_evt_i,
	input wire logic [EVT_DEPTH_W-1:0] evt_size_i,
	input wire logic [EVT_DEPTH_W-1:0] evt_level_i,
	input wire logic [EVT_DEPTH_W-1:0] evt_watermark_i,
	input wire logic tx_fifo_empty_i,
	// rx fifo 1 store side
	input wire logic rx_store_done_i,
	input wire logic rx_store_partial_i,
	input wire logic [6:0] rx_fifo1_level_i,
	// configuration outputs
	output cbt_nbt_s nbt_o,
	output logic [9:0] quantum_clocks_o,
	output logic [8:0] bit_time_quanta_o,
	output logic rx_fifo1_overwrite_mode_o,
	output logic [6:0] rx_fifo1_eff_size_o,
	output logic [15:0] rx_fifo1_start_address_o,
	output logic [6:0] rx_fifo1_put_index_o,
	output logic tx_abort_o,
	output logic restricted_o,
	output logic init_o
);
	// ****************************************************
	// state
	// ****************************************************
	logic [31:0] nbt_reg;
	logic [31:0] core_ctrl_reg;
	logic [31:0] irq_flags_reg;
	logic [31:0] rxf1_reg;
	cbt_rxf1_s rxf1_cfg;
	logic [6:0] put_index_reg;
	logic [31:0] flag_set;
	logic [31:0] wmask;
	logic [31:0] rdata;
	logic wr_stb;
	logic tx_abort_reg;
	logic evt_full;
	logic evt_wm;
	logic [6:0] eff_size;
	logic [6:0] wm_now;
	logic wm_active;
	cbt_bus_e bus_reg;

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	function automatic logic [6:0] clamp64(input logic [6:0] v);
		clamp64 = (v > CBT_F1_MAX) ? CBT_F1_MAX : v;
	endfunction

	assign wmask = lane_mask(sel_i);
	assign wr_stb = cyc_i && stb_i && we_i && (bus_reg == CBT_IDLE);

	// ****************************************************
	// bus handshake: one wait cycle, ack for one cycle
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_reg <= CBT_IDLE;
		end else begin
			case (bus_reg)
				CBT_IDLE: if (cyc_i && stb_i) bus_reg <= CBT_ACK;
				CBT_ACK: bus_reg <= CBT_IDLE;
				default: bus_reg <= CBT_IDLE;
			endcase
		end
	end
	assign ack_o = (bus_reg == CBT_ACK);
	assign err_o = 1'b0;

	// ****************************************************
	// core control: init, change enable, restricted mode
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_ctrl_reg <= CBT_CORE_CTRL_RST;
		end else begin
			if (wr_stb && adr_i == CBT_CORE_CTRL_OFF && sel_i[0]) begin
				core_ctrl_reg[CBT_INIT_BIT] <= dat_i[CBT_INIT_BIT];
				// change enable only while init is already set
				if (core_ctrl_reg[CBT_INIT_BIT]) begin
					core_ctrl_reg[CBT_CFG_CHANGE_BIT] <= dat_i[CBT_CFG_CHANGE_BIT]
						&& dat_i[CBT_INIT_BIT];
				end else begin
					core_ctrl_reg[CBT_CFG_CHANGE_BIT] <= 1'b0;
				end
				core_ctrl_reg[CBT_ROM_BIT] <= dat_i[CBT_ROM_BIT];
			end
			// failure entry wins over a software clear
			if (tx_evt_i.ram_late) begin
				core_ctrl_reg[CBT_ROM_BIT] <= 1'b1;
			end
		end
	end

	// ****************************************************
	// nominal bit timing
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nbt_reg <= CBT_NBT_RST;
		end else if (wr_stb && adr_i == CBT_NBT_OFF && core_ctrl_reg[CBT_CFG_CHANGE_BIT]
				&& core_ctrl_reg[CBT_INIT_BIT]) begin
			nbt_reg <= (nbt_reg & ~wmask) | (dat_i & wmask & 32'hFFFFFF7F);
		end
	end
	assign nbt_o = cbt_nbt_s'(nbt_reg);
	// quantum length 1..512 clocks
	assign quantum_clocks_o = {1'b0, nbt_o.prescaler} + 10'h001;
	// sync + seg1+1 + seg2+1 gives 3..385 quanta
	assign bit_time_quanta_o = 9'h003 + {1'b0, nbt_o.seg_before} + {2'b00, nbt_o.seg_after[6:0]};

	// ****************************************************
	// rx fifo 1 configuration
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxf1_reg <= 32'h00000000;
		end else if (wr_stb && adr_i == CBT_RXF1_CFG_OFF && core_ctrl_reg[CBT_CFG_CHANGE_BIT]
				&& core_ctrl_reg[CBT_INIT_BIT]) begin
			// bit 23 reserved, low two address bits dropped
			rxf1_reg <= (rxf1_reg & ~wmask) | (dat_i & wmask & {16'hFF7F, CBT_RXF1_SA_MASK});
		end
	end
	assign rxf1_cfg = cbt_rxf1_s'(rxf1_reg);
	assign rx_fifo1_overwrite_mode_o = rxf1_cfg.overwrite_mode;
	assign eff_size = clamp64(rxf1_cfg.size);
	assign rx_fifo1_eff_size_o = eff_size;
	assign rx_fifo1_start_address_o = rxf1_cfg.start_address & CBT_RXF1_SA_MASK;
	assign wm_now = rxf1_cfg.watermark;
	// zero or above 64 disables the watermark
	assign wm_active = (wm_now != 7'h00) && (wm_now <= CBT_F1_MAX)
		&& (rx_fifo1_level_i >= wm_now);

	// ****************************************************
	// rx fifo 1 put index
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i || core_ctrl_reg[CBT_INIT_BIT]) begin
			put_index_reg <= 7'h00;
		end else if (rx_store_done_i && !rx_store_partial_i && eff_size != 7'h00) begin
			// partial stores leave the index, next one overwrites
			put_index_reg <= (put_index_reg + 7'h01 >= eff_size) ? 7'h00
				: put_index_reg + 7'h01;
		end
	end
	assign rx_fifo1_put_index_o = put_index_reg;

	// ****************************************************
	// tx event fifo conditions
	// ****************************************************
	assign evt_full = (evt_size_i != '0) && (evt_level_i >= evt_size_i);
	assign evt_wm = (evt_watermark_i != '0) && (evt_level_i >= evt_watermark_i);

	always_comb begin
		flag_set = 32'h00000000;
		flag_set[CBT_MRAF_BIT] = tx_evt_i.ram_late;
		flag_set[CBT_TS_WRAP_BIT] = tx_evt_i.ts_wrap;
		// zero-size fifo write counts as lost
		flag_set[CBT_EVT_LOST_BIT] = tx_evt_i.evt_lost
			|| (tx_evt_i.evt_write && evt_size_i == '0);
		flag_set[CBT_EVT_FULL_BIT] = evt_full;
		flag_set[CBT_EVT_WM_BIT] = evt_wm;
		flag_set[CBT_EVT_NEW_BIT] = tx_evt_i.evt_write && evt_size_i != '0;
		flag_set[CBT_TXQ_EMPTY_BIT] = tx_fifo_empty_i;
		flag_set[CBT_CANCEL_BIT] = tx_evt_i.cancel_done;
		flag_set[CBT_RXF1_WM_BIT] = wm_active;
	end

	// ****************************************************
	// interrupt flags: write one to clear, set wins
	// ****************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_flags_reg <= 32'h00000000;
		end else if (wr_stb && adr_i == CBT_IRQ_FLAGS_OFF) begin
			irq_flags_reg <= ((irq_flags_reg & ~(dat_i & wmask)) | flag_set)
				& CBT_FLAG_MASK;
		end else begin
			irq_flags_reg <= (irq_flags_reg | flag_set) & CBT_FLAG_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_abort_reg <= 1'b0;
		end else begin
			tx_abort_reg <= tx_evt_i.ram_late;
		end
	end
	assign tx_abort_o = tx_abort_reg;
	assign restricted_o = core_ctrl_reg[CBT_ROM_BIT];
	// software polls this before rewriting init
	assign init_o = core_ctrl_reg[CBT_INIT_BIT];

	// ****************************************************
	// read data
	// ****************************************************
	always_comb begin
		if (adr_i == CBT_CORE_CTRL_OFF) begin
			rdata = core_ctrl_reg & 32'h00000007;
		end else if (adr_i == CBT_NBT_OFF) begin
			rdata = nbt_reg;
		end else if (adr_i == CBT_IRQ_FLAGS_OFF) begin
			rdata = irq_flags_reg;
		end else if (adr_i == CBT_RXF1_CFG_OFF) begin
			rdata = rxf1_reg;
		end else if (adr_i == CBT_TQ_STATUS_OFF) begin
			rdata = {6'h00, put_index_reg, bit_time_quanta_o, quantum_clocks_o};
		end else begin
			rdata = 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else if (cyc_i && stb_i && !we_i && bus_reg == CBT_IDLE) begin
			dat_o <= rdata;
		end
	end
endmodule

// ==== sim/cbt_core_chk.sv ====
// port assertions for the bit timing, tx flag and rx fifo 1 block
// bound to every cbt_core instance; one clock domain
`timescale 1ns/1ps
module cbt_core_chk
	import cbt_pkg::*;
(
	// watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic ack_o,
	input wire cbt_tx_evt_s tx_evt_i,
	input wire logic rx_store_done_i,
	input wire logic rx_store_partial_i,
	input wire cbt_nbt_s nbt_o,
	input wire logic [9:0] quantum_clocks_o,
	input wire logic [8:0] bit_time_quanta_o,
	input wire logic [6:0] rx_fifo1_eff_size_o,
	input wire logic [15:0] rx_fifo1_start_address_o,
	input wire logic [6:0] rx_fifo1_put_index_o,
	input wire logic tx_abort_o,
	input wire logic restricted_o,
	input wire logic init_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack timing");
	property p_timing; bit_time_quanta_o == 9'h003 + nbt_o.seg_before + nbt_o.seg_after[6:0]
		&& bit_time_quanta_o <= 9'h181 && quantum_clocks_o == nbt_o.prescaler + 10'h001; endproperty
	a_timing: assert property (p_timing) else $error("bit timing");
	property p_nbt; !$stable(nbt_o) |-> $past(rst_i)
		|| $past(cyc_i && stb_i && we_i && !ack_o && adr_i == CBT_NBT_OFF && init_o); endproperty
	a_nbt: assert property (p_nbt) else $error("timing changed");
	property p_abort; tx_evt_i.ram_late |=> tx_abort_o && restricted_o; endproperty
	a_abort: assert property (p_abort) else $error("no abort");
	property p_restr; $fell(restricted_o) |-> $past(rst_i)
		|| $past(cyc_i && stb_i && we_i && !ack_o && adr_i == CBT_CORE_CTRL_OFF); endproperty
	a_restr: assert property (p_restr) else $error("restricted left");
	property p_part; rx_store_done_i && rx_store_partial_i && !init_o && !we_i
		|=> $stable(rx_fifo1_put_index_o); endproperty
	a_part: assert property (p_part) else $error("put moved");
	property p_put; rx_store_done_i && !rx_store_partial_i && !init_o && !we_i
		&& rx_fifo1_eff_size_o != 7'h00 |=> rx_fifo1_put_index_o ==
		(($past(rx_fifo1_put_index_o) + 7'h01 == rx_fifo1_eff_size_o) ? 7'h00
		: $past(rx_fifo1_put_index_o) + 7'h01); endproperty
	a_put: assert property (p_put) else $error("put index");
	property p_size; rx_fifo1_eff_size_o <= CBT_F1_MAX; endproperty
	a_size: assert property (p_size) else $error("size");
	property p_addr; rx_fifo1_start_address_o[1:0] == 2'h0; endproperty
	a_addr: assert property (p_addr) else $error("address");
endmodule
bind cbt_core cbt_core_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .ack_o(ack_o), .tx_evt_i(tx_evt_i), .init_o(init_o),
	.rx_store_done_i(rx_store_done_i), .rx_store_partial_i(rx_store_partial_i), .nbt_o(nbt_o),
	.quantum_clocks_o(quantum_clocks_o), .bit_time_quanta_o(bit_time_quanta_o),
	.rx_fifo1_eff_size_o(rx_fifo1_eff_size_o), .rx_fifo1_put_index_o(rx_fifo1_put_index_o),
	.rx_fifo1_start_address_o(rx_fifo1_start_address_o), .tx_abort_o(tx_abort_o),
	.restricted_o(restricted_o));

// ==== sim/cbt_far_side.sv ====
// far-side model: tx handler event pulses and rx fifo 1 store strobes
// tasks are called by the bench just after a clock edge
`timescale 1ns/1ps
module cbt_far_side
	import cbt_pkg::*;
(
	// clock
	input wire logic clk_i,
	// handler strobes
	output cbt_tx_evt_s evt_o,
	output logic done_o,
	output logic part_o
);
	initial begin
		evt_o = '0;
		done_o = '0;
		part_o = '0;
	end
	task automatic fire(input cbt_tx_evt_s e);
		evt_o <= e;
		@(posedge clk_i);
		evt_o <= '0;
	endtask
	// partial qualifier is only meaningful alongside done
	task automatic store(input logic p);
		done_o <= 1'b1;
		part_o <= p;
		@(posedge clk_i);
		done_o <= '0;
		part_o <= '0;
	endtask
endmodule

// ==== sim/test_cbt_core.sv ====
// self-checking bench for cbt_core over classic wishbone
// assumes the far-side model and the bound checker
`timescale 1ns/1ps
module test_cbt_core
	import cbt_pkg::*;
;
	logic clk_i = '0, rst_i = 1'b1, cyc = '0, stb = '0, we = '0, tx_empty = '0;
	logic ack, done, part;
	logic [7:0] adr = '0;
	logic [31:0] dat = '0, q, rdat;
	logic [5:0] esz = 6'h04, elv = '0, ewm = '0;
	logic [6:0] rlv = '0, esize, put;
	logic [6:0] wms[3] = '{7'h00, 7'h03, 7'h41};
	logic [9:0] tq;
	logic [8:0] bt;
	logic om;
	logic [15:0] sa;
	cbt_tx_evt_s evt;
	int mismatches = 0, n_checks = 0, cycles = 0;
	int exp_bit[5] = '{10, 17, 15, 12, 16};
	cbt_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .err_o(),
		.tx_evt_i(evt), .evt_size_i(esz), .evt_level_i(elv), .evt_watermark_i(ewm),
		.tx_fifo_empty_i(tx_empty), .rx_store_done_i(done), .rx_store_partial_i(part),
		.rx_fifo1_level_i(rlv), .nbt_o(), .quantum_clocks_o(tq), .bit_time_quanta_o(bt),
		.rx_fifo1_overwrite_mode_o(om), .rx_fifo1_eff_size_o(esize),
		.rx_fifo1_start_address_o(sa), .rx_fifo1_put_index_o(put), .tx_abort_o(),
		.restricted_o(), .init_o());
	cbt_far_side u_far (.clk_i(clk_i), .evt_o(evt), .done_o(done), .part_o(part));
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; ack sampled at the rising edge, read data taken there
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= '0;
		stb <= '0;
		if (n >= 20) mismatches++;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(a, 1'b0, '0);
		chk(q, exp);
	endtask
	task automatic wrap_up;
		if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= '0;
		@(posedge clk_i);
		rd(CBT_NBT_OFF, CBT_NBT_RST);
		rd(CBT_CORE_CTRL_OFF, CBT_CORE_CTRL_RST);
		wb(CBT_NBT_OFF, 1'b1, 32'h12345678);
		rd(CBT_NBT_OFF, CBT_NBT_RST);
		wb(CBT_CORE_CTRL_OFF, 1'b1, 32'h00000003);
		wb(CBT_NBT_OFF, 1'b1, '1);
		rd(CBT_NBT_OFF, 32'hFFFFFF7F);
		chk({tq, 13'h0000, bt}, {10'h200, 13'h0000, 9'h181});
		wb(CBT_NBT_OFF, 1'b1, 32'h00000100);
		chk({tq, 13'h0000, bt}, {10'h001, 13'h0000, 9'h004});
		rd(CBT_TQ_STATUS_OFF, 32'h00001001);
		wb(CBT_RXF1_CFG_OFF, 1'b1, '1);
		rd(CBT_RXF1_CFG_OFF, 32'hFF7FFFFC);
		chk({om, esize, sa}, {1'b1, 7'h40, 16'hFFFC});
		rlv <= 7'h03;
		foreach (wms[i]) begin
			wb(CBT_RXF1_CFG_OFF, 1'b1, {1'b0, wms[i], 8'h05, 16'h0000});
			wb(CBT_IRQ_FLAGS_OFF, 1'b1, '1);
			rd(CBT_IRQ_FLAGS_OFF, {22'h0, wms[i] == 7'h03, 9'h000});
		end
		chk({om, esize}, {1'b0, 7'h05});
		rlv <= '0;
		for (int i = 0; i < 5; i++) begin
			u_far.fire(cbt_tx_evt_s'(5'h01 << i));
			rd(CBT_IRQ_FLAGS_OFF, 32'h1 << exp_bit[i]);
			wb(CBT_IRQ_FLAGS_OFF, 1'b1, '1);
		end
		rd(CBT_CORE_CTRL_OFF, 32'h00000007);
		wb(CBT_CORE_CTRL_OFF, 1'b1, 32'h00000003);
		rd(CBT_CORE_CTRL_OFF, 32'h00000003);
		elv <= 6'h04;
		ewm <= 6'h02;
		tx_empty <= 1'b1;
		wb(CBT_IRQ_FLAGS_OFF, 1'b1, '1);
		rd(CBT_IRQ_FLAGS_OFF, 32'h00006800);
		{esz, elv, ewm, tx_empty} <= '0;
		wb(CBT_IRQ_FLAGS_OFF, 1'b1, '1);
		u_far.fire(cbt_tx_evt_s'(5'h08));
		wb(CBT_IRQ_FLAGS_OFF, 1'b0, '0);
		chk(q & 32'h00008000, 32'h00008000);
		wb(CBT_CORE_CTRL_OFF, 1'b1, 32'h00000000);
		rd(CBT_CORE_CTRL_OFF, 32'h00000000);
		wb(CBT_CORE_CTRL_OFF, 1'b1, 32'h00000002);
		rd(CBT_CORE_CTRL_OFF, 32'h00000000);
		wb(CBT_RXF1_CFG_OFF, 1'b1, '0);
		chk({25'h0, esize}, 32'h00000005);
		for (int i = 0; i < 6; i++) begin
			u_far.store(i == 1);
			@(posedge clk_i);
			if (i == 2) chk({25'h0, put}, 32'h00000002);
		end
		chk({25'h0, put}, 32'h00000000);
		wrap_up();
	end
endmodule
